// [common/hsbs_pkg.sv]
/*
 Shared constants for the hot-swap bus supervisor: register map, field
 layout, policy codes, blink counts, timing and the supervisor states.
 Assumes a 125 MHz system clock and an APB master with 32-bit data.
*/
package hsbs_pkg;
	localparam int CLK_MHZ = 125;
	localparam int STARTUP_US = 100;
	localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
	localparam int BLINK_HALF_MS = 250;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
	localparam int BLINK_GAP_HALVES = 4;
	localparam int MAX_SLOTS = 8;

	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DECL = 8'h04;
	localparam logic [7:0] OFS_CMD = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_DIAG = 8'h10;

	localparam int POLICY_W = 3;
	localparam int CTRL_POLICY_LSB = 0;
	localparam logic [2:0] POL_DIS_DECL = 3'h0;
	localparam logic [2:0] POL_DIS = 3'h1;
	localparam logic [2:0] POL_DIS_NOSC = 3'h2;
	localparam logic [2:0] POL_EN_SC_DECL = 3'h3;
	localparam logic [2:0] POL_EN_SC = 3'h4;
	localparam logic [2:0] POL_EN_NOSC = 3'h5;
	localparam logic [2:0] POLICY_RST = POL_EN_NOSC;
	localparam logic [7:0] DECL_RST = 8'h00;

	localparam int CMD_WARM = 0;
	localparam int CMD_COLD = 1;
	localparam int CMD_ORIGIN = 2;
	localparam int CMD_DOWNLOAD = 3;

	localparam logic [2:0] BLINKS_NONE = 3'h0;
	localparam logic [2:0] BLINKS_TWO = 3'h2;
	localparam logic [2:0] BLINKS_FOUR = 3'h4;

	localparam int ST_RUN_BIT = 0;
	localparam int ST_STARTUP_BIT = 1;
	localparam int ST_STOP_BIT = 2;
	localparam int ST_WAITDL_BIT = 3;
	localparam int ST_POLICY_LSB = 4;
	localparam int ST_BLINK_LSB = 8;
	localparam int ST_FAILSAFE_BIT = 12;
	localparam int ST_ABNORMAL_BIT = 13;
	localparam int DIAG_ABSENT_LSB = 0;
	localparam int DIAG_INCOMPAT_LSB = 8;
	localparam int DIAG_NONDECL_LSB = 16;

	typedef enum logic [1:0] {st_startup, st_run, st_stop, st_wait_dl} hsbs_state_t;
endpackage

// [rtl/hsbs_blink.sv]
/*
 Diagnostic indicator blink generator: a burst of the requested number of
 flashes, then a dark gap, repeated. Assumes count is steady for a burst.
*/
`timescale 1ns/10ps
module hsbs_blink #(
	parameter int HALF_CYC = 31250000,
	parameter int GAP_HALVES = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] count,
	output logic led
);
	logic [31:0] tick_cnt;
	logic [4:0] step;
	logic tick;
	logic [4:0] last_step;

	assign tick = (tick_cnt == 32'(HALF_CYC - 1));
	assign last_step = 5'({count, 1'b0} + 5'(GAP_HALVES) - 5'h01);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt <= 32'h0;
		else if (tick)
			tick_cnt <= 32'h0;
		else
			tick_cnt <= tick_cnt + 32'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			step <= 5'h00;
		else if (tick)
			step <= (step >= last_step) ? 5'h00 : step + 5'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			led <= 1'b0;
		else
			led <= (count != 3'h0) && (step < 5'({count, 1'b0})) && !step[0];
	end
endmodule // hsbs_blink

// [rtl/hsbs_supervisor.sv]
/*
 Hot-swap bus supervisor: classifies bus slots, applies the selected
 policy to move between startup, Run, Stop and wait-for-download, drives
 the diagnostic indicator and the output fail-safe, over an APB slave.
 Assumes slot status pins are asynchronous and an APB master on pclk.
*/
`timescale 1ns/10ps
module hsbs_supervisor import hsbs_pkg::*; #(
	parameter int N_SLOTS = 8,
	parameter int STARTUP_CYCLES = STARTUP_CYC,
	parameter int BLINK_HALF_CYCLES = BLINK_HALF_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [N_SLOTS-1:0] slot_present_pin,
	input wire logic [N_SLOTS-1:0] slot_respond_pin,
	input wire logic [N_SLOTS-1:0] slot_model_ok_pin,
	output logic run_mode,
	output logic outputs_failsafe,
	output logic [N_SLOTS-1:0] input_hold,
	output logic diagnostic_indicator
);
	generate
		if (N_SLOTS < 1 || N_SLOTS > MAX_SLOTS || STARTUP_CYCLES < 1 || BLINK_HALF_CYCLES < 1)
		begin : g_bad_param
			$error("hsbs_supervisor: unsupported parameter value");
		end
	endgenerate

	logic [N_SLOTS-1:0] pres_m, pres_s, resp_m, resp_s, model_m, model_s;
	logic [POLICY_W-1:0] policy;
	logic [POLICY_W-1:0] act_policy;
	logic [N_SLOTS-1:0] declared;
	hsbs_state_t state;
	hsbs_state_t next_state;
	logic [31:0] startup_cnt;
	logic ran;
	logic [2:0] stop_code;
	logic [2:0] next_stop_code;
	logic [N_SLOTS-1:0] snap_pres, snap_model;
	logic [N_SLOTS-1:0] absent, incompat, nondecl;
	logic abn_decl, abn_any, bus_changed, startup_done;
	logic startup_fault, run_fault, decl_only;
	logic [2:0] blink_code;
	logic wr_en, rd_en, wr_cmd;
	logic cmd_restart, cmd_origin, cmd_download;
	logic [31:0] next_rdata;
	logic addr_ok;

	// Two-flop synchronisers for the slot status pins.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pres_m <= '0;
			pres_s <= '0;
			resp_m <= '0;
			resp_s <= '0;
			model_m <= '0;
			model_s <= '0;
		end
		else
		begin
			pres_m <= slot_present_pin;
			pres_s <= pres_m;
			resp_m <= slot_respond_pin;
			resp_s <= resp_m;
			model_m <= slot_model_ok_pin;
			model_s <= model_m;
		end
	end

	// Slot classification.
	assign incompat = declared & pres_s & ~model_s;
	assign absent = declared & (~pres_s | ~resp_s);
	assign nondecl = ~declared & pres_s;
	assign abn_decl = |(incompat | absent);
	assign abn_any = abn_decl | (|nondecl);
	assign decl_only = (act_policy == POL_DIS_DECL) || (act_policy == POL_EN_SC_DECL);
	assign bus_changed = (snap_pres != pres_s) || (snap_model != (model_s & pres_s));
	assign startup_done = (startup_cnt == 32'(STARTUP_CYCLES - 1));

	always_comb
	begin
		case (act_policy)
			POL_DIS_DECL, POL_EN_SC_DECL: startup_fault = abn_decl;
			POL_DIS, POL_EN_SC: startup_fault = abn_any;
			default: startup_fault = 1'b0;
		endcase
	end

	always_comb
	begin
		case (act_policy)
			POL_DIS_DECL: run_fault = abn_decl;
			POL_DIS: run_fault = abn_any;
			POL_DIS_NOSC: run_fault = bus_changed;
			default: run_fault = 1'b0;
		endcase
	end

	// APB decode; a transfer completes at the edge where pready is high.
	assign wr_en = psel && penable && pready && pwrite;
	assign rd_en = psel && penable && !pready && !pwrite;
	assign wr_cmd = wr_en && (paddr == OFS_CMD);
	assign cmd_origin = wr_cmd && pwdata[CMD_ORIGIN];
	assign cmd_restart = wr_cmd && (pwdata[CMD_WARM] || pwdata[CMD_COLD]);
	assign cmd_download = wr_cmd && pwdata[CMD_DOWNLOAD];
	assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_DECL) || (paddr == OFS_CMD)
		|| (paddr == OFS_STATUS) || (paddr == OFS_DIAG);

	always_comb
	begin
		next_state = state;
		next_stop_code = stop_code;
		if (cmd_origin)
			next_state = st_wait_dl;
		else if ((cmd_restart || cmd_download) && state != st_wait_dl)
			next_state = st_startup;
		else
		begin
			case (state)
				st_startup:
					if (startup_done)
					begin
						if (startup_fault)
						begin
							next_state = st_stop;
							next_stop_code = BLINKS_FOUR;
						end
						else
							next_state = st_run;
					end
				st_run:
					if (run_fault)
					begin
						next_state = st_stop;
						next_stop_code = (act_policy == POL_DIS_NOSC) ? BLINKS_TWO : BLINKS_FOUR;
					end
				st_stop:
					next_state = st_stop;
				st_wait_dl:
					if (cmd_download)
						next_state = st_startup;
				default:
					next_state = st_startup;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= st_startup;
			stop_code <= BLINKS_NONE;
		end
		else
		begin
			state <= next_state;
			stop_code <= next_stop_code;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			startup_cnt <= 32'h0;
		else if (state != st_startup || next_state != st_startup)
			startup_cnt <= 32'h0;
		else if (!startup_done)
			startup_cnt <= startup_cnt + 32'h1;
	end

	// Policy is taken only while starting up and held otherwise.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			act_policy <= POLICY_RST;
		else if (state == st_startup)
			act_policy <= policy;
	end

	// Bus content snapshot taken on entry to Run.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			snap_pres <= '0;
			snap_model <= '0;
		end
		else if (state != st_run && next_state == st_run)
		begin
			snap_pres <= pres_s;
			snap_model <= model_s & pres_s;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ran <= 1'b0;
		else if (next_state == st_startup || next_state == st_wait_dl)
			ran <= 1'b0;
		else if (next_state == st_run)
			ran <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_mode <= 1'b0;
			outputs_failsafe <= 1'b1;
			input_hold <= '0;
		end
		else
		begin
			run_mode <= (state == st_run);
			outputs_failsafe <= (state != st_run) && !ran;
			input_hold <= ~pres_s;
		end
	end

	// Stop shows its own code; otherwise any abnormality gives two flashes.
	assign blink_code = (state == st_stop) ? stop_code
		: (abn_any ? BLINKS_TWO : BLINKS_NONE);

	hsbs_blink #(
		.HALF_CYC(BLINK_HALF_CYCLES),
		.GAP_HALVES(BLINK_GAP_HALVES)
	) u_blink (
		.pclk(pclk),
		.presetn(presetn),
		.count(blink_code),
		.led(diagnostic_indicator)
	);

	// Software registers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			policy <= POLICY_RST;
		else if (wr_en && paddr == OFS_CTRL)
			policy <= pwdata[CTRL_POLICY_LSB +: POLICY_W];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			declared <= DECL_RST[N_SLOTS-1:0];
		else if (wr_en && paddr == OFS_DECL)
			declared <= pwdata[N_SLOTS-1:0];
	end

	always_comb
	begin
		next_rdata = 32'h0;
		case (paddr)
			OFS_CTRL: next_rdata[CTRL_POLICY_LSB +: POLICY_W] = policy;
			OFS_DECL: next_rdata[N_SLOTS-1:0] = declared;
			OFS_STATUS:
			begin
				next_rdata[ST_RUN_BIT] = (state == st_run);
				next_rdata[ST_STARTUP_BIT] = (state == st_startup);
				next_rdata[ST_STOP_BIT] = (state == st_stop);
				next_rdata[ST_WAITDL_BIT] = (state == st_wait_dl);
				next_rdata[ST_POLICY_LSB +: POLICY_W] = act_policy;
				next_rdata[ST_BLINK_LSB +: 3] = blink_code;
				next_rdata[ST_FAILSAFE_BIT] = outputs_failsafe;
				next_rdata[ST_ABNORMAL_BIT] = decl_only ? abn_decl : abn_any;
			end
			OFS_DIAG:
			begin
				next_rdata[DIAG_ABSENT_LSB +: N_SLOTS] = absent;
				next_rdata[DIAG_INCOMPAT_LSB +: N_SLOTS] = incompat;
				next_rdata[DIAG_NONDECL_LSB +: N_SLOTS] = nondecl;
			end
			default: next_rdata = 32'h0;
		endcase
	end

	// One wait state: pready rises in the second access cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addr_ok;
			prdata <= rd_en ? next_rdata : 32'h0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_decl_abn_stop: assert property (
		state == st_run && act_policy == POL_DIS_DECL && abn_decl && !wr_cmd
		|=> state == st_stop ##0 blink_code == BLINKS_FOUR)
		else $error("declared-only disabled policy did not stop with four flashes");
	a_nondecl_keep_run: assert property (
		state == st_run && act_policy == POL_DIS_DECL && !abn_decl && !wr_cmd
		|=> state == st_run)
		else $error("non-declared module left Run under declared-only policy");
	a_dis_nondecl_stop: assert property (
		state == st_run && act_policy == POL_DIS && |nondecl && !wr_cmd
		|=> state == st_stop ##0 blink_code == BLINKS_FOUR)
		else $error("disabled policy ignored a non-declared module");
	a_nosc_change_stop: assert property (
		state == st_run && act_policy == POL_DIS_NOSC && bus_changed && !wr_cmd
		|=> state == st_stop ##0 blink_code == BLINKS_TWO)
		else $error("bus change did not stop with two flashes");
	a_enabled_keep_run: assert property (
		state == st_run && act_policy >= POL_EN_SC_DECL && !wr_cmd |=> state == st_run)
		else $error("enabled policy left Run without a command");
	a_stop_sticks: assert property (
		state == st_stop && !wr_cmd |=> state == st_stop)
		else $error("Stop was left without a restart command");
	a_restart_startup: assert property (
		cmd_restart && !cmd_origin && state != st_wait_dl |=> state == st_startup)
		else $error("restart did not begin a new startup");
	a_origin_wait_dl: assert property (
		cmd_origin |=> state == st_wait_dl ##1 (state == st_wait_dl || $past(wr_cmd)))
		else $error("origin reset did not wait for a download");
	a_failsafe_out: assert property (
		state == st_stop && !ran |=> outputs_failsafe)
		else $error("outputs not fail-safe after Stop before Run");
	a_policy_held: assert property (
		state != st_startup && $past(state) != st_startup |-> $stable(act_policy))
		else $error("active policy changed outside startup");
	a_input_hold: assert property (
		1'b1 |=> input_hold == ~$past(pres_s))
		else $error("input hold does not follow module removal");
	a_startup_len: assert property (
		$rose(state == st_startup) |-> (state == st_startup)[*2])
		else $error("startup ended too soon");

	c_reach_run: cover property ($rose(state == st_run));
	c_run_to_stop: cover property (state == st_run ##1 state == st_stop);
	c_wait_download: cover property (state == st_wait_dl ##1 state == st_startup);
endmodule // hsbs_supervisor

// [test/hsbs_io_rack.sv]
/*
 Model of the I/O modules on the backplane: drives the slot status pins.
 Assumes the bench picks which slots hold modules, which are mute and
 which carry a model other than the declared one.
*/
`timescale 1ns/10ps
module hsbs_io_rack (
	input wire logic pclk,
	input wire logic [7:0] inserted,
	input wire logic [7:0] wrong_model,
	input wire logic [7:0] mute,
	output logic [7:0] slot_present_pin,
	output logic [7:0] slot_respond_pin,
	output logic [7:0] slot_model_ok_pin
);
	logic [7:0] churn = 8'h55;
	always @(posedge pclk)
	begin
		churn <= ~churn;
	end
	// An empty slot leaves the model line floating, so it changes every cycle.
	assign slot_present_pin = inserted;
	assign slot_respond_pin = inserted & ~mute;
	assign slot_model_ok_pin = (inserted & ~wrong_model) | (~inserted & churn);
endmodule // hsbs_io_rack

// [test/tb_hsbs_supervisor.sv]
/*
 Self-checking bench for the hot-swap bus supervisor over APB.
 Assumes short startup and blink counts set through the parameters.
*/
`timescale 1ns/10ps
module tb_hsbs_supervisor import hsbs_pkg::*;;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, s;
	logic pready, pslverr, run_mode, outputs_failsafe, led, led_d, e;
	logic [7:0] pres, resp, mok, input_hold;
	logic [7:0] ins = 8'h00;
	logic [7:0] bad = 8'h00;
	logic [7:0] mute = 8'h00;
	int error_cnt = 0;
	int check_count = 0;
	int rises = 0;
	int r0;
	hsbs_io_rack u_hsbs_io_rack (.pclk(pclk), .inserted(ins), .wrong_model(bad), .mute(mute),
		.slot_present_pin(pres), .slot_respond_pin(resp), .slot_model_ok_pin(mok));
	hsbs_supervisor #(.N_SLOTS(8), .STARTUP_CYCLES(4), .BLINK_HALF_CYCLES(2)) u_hsbs_supervisor (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.slot_present_pin(pres), .slot_respond_pin(resp), .slot_model_ok_pin(mok),
		.run_mode(run_mode), .outputs_failsafe(outputs_failsafe), .input_hold(input_hold),
		.diagnostic_indicator(led));
	initial
	begin
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		led_d <= led;
		if (led === 1'b1 && led_d === 1'b0)
			rises <= rises + 1;
	end
	task automatic end_sim();
		if (error_cnt == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		s = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic cmd(input int bitno);
		apb(1'b1, OFS_CMD, 32'h1 << bitno);
		idle(40);
	endtask
	task automatic boot(input logic [2:0] pol, input logic [7:0] decl, input logic [7:0] i,
		input logic [7:0] b, input logic [7:0] m);
		apb(1'b1, OFS_CTRL, {29'h0, pol});
		apb(1'b1, OFS_DECL, {24'h0, decl});
		ins <= i;
		bad <= b;
		mute <= m;
		cmd(CMD_WARM);
	endtask
	task automatic expect_mode(input logic [2:0] pol, input logic run, input logic [2:0] bl);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(s[ST_RUN_BIT], run);
		chk(s[ST_STOP_BIT], !run);
		chk(s[ST_POLICY_LSB +: 3], pol);
		chk(run_mode, run);
		chk(s[ST_BLINK_LSB +: 3], bl);
	endtask
	task automatic tcase(input logic [2:0] pol, input logic [7:0] i, input logic [7:0] b,
		input logic [7:0] m, input logic run);
		boot(pol, 8'h03, i, b, m);
		expect_mode(pol, run, !run ? BLINKS_FOUR
			: ((i == 8'h03 && b == 8'h00 && m == 8'h00) ? BLINKS_NONE : BLINKS_TWO));
		chk(outputs_failsafe, !run);
	endtask
	initial
	begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		end_sim();
	end
	initial
	begin
		idle(3);
		presetn <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(s, {29'h0, POLICY_RST});
		apb(1'b0, OFS_DECL, 32'h0);
		chk(s, {24'h0, DECL_RST});
		apb(1'b0, 8'h20, 32'h0);
		chk({e, s}, {1'b1, 32'h0});
		tcase(POL_DIS_DECL, 8'h03, 8'h00, 8'h00, 1'b1);
		tcase(POL_DIS_DECL, 8'h07, 8'h00, 8'h00, 1'b1);
		tcase(POL_DIS_DECL, 8'h01, 8'h00, 8'h00, 1'b0);
		tcase(POL_DIS_DECL, 8'h03, 8'h00, 8'h02, 1'b0);
		tcase(POL_DIS, 8'h07, 8'h00, 8'h00, 1'b0);
		tcase(POL_DIS, 8'h03, 8'h01, 8'h00, 1'b0);
		tcase(POL_DIS_NOSC, 8'h01, 8'h00, 8'h00, 1'b1);
		tcase(POL_EN_SC_DECL, 8'h07, 8'h00, 8'h00, 1'b1);
		tcase(POL_EN_SC_DECL, 8'h01, 8'h00, 8'h00, 1'b0);
		tcase(POL_EN_SC, 8'h07, 8'h00, 8'h00, 1'b0);
		tcase(POL_EN_NOSC, 8'h05, 8'h02, 8'h00, 1'b1);
		tcase(POL_DIS_DECL, 8'h03, 8'h00, 8'h00, 1'b1);
		ins <= 8'h07;
		idle(20);
		expect_mode(POL_DIS_DECL, 1'b1, BLINKS_TWO);
		chk(s[ST_ABNORMAL_BIT], 1'b0);
		apb(1'b0, OFS_DIAG, 32'h0);
		chk(s[DIAG_NONDECL_LSB +: 8], 8'h04);
		ins <= 8'h02;
		idle(20);
		expect_mode(POL_DIS_DECL, 1'b0, BLINKS_FOUR);
		r0 = rises;
		idle(24);
		chk(rises - r0, 4);
		ins <= 8'h03;
		idle(20);
		expect_mode(POL_DIS_DECL, 1'b0, BLINKS_FOUR);
		chk(outputs_failsafe, 1'b0);
		cmd(CMD_COLD);
		expect_mode(POL_DIS_DECL, 1'b1, BLINKS_NONE);
		apb(1'b1, OFS_CTRL, {29'h0, POL_DIS});
		expect_mode(POL_DIS_DECL, 1'b1, BLINKS_NONE);
		boot(POL_DIS_NOSC, 8'h03, 8'h03, 8'h00, 8'h00);
		ins <= 8'h07;
		idle(20);
		expect_mode(POL_DIS_NOSC, 1'b0, BLINKS_TWO);
		r0 = rises;
		idle(16);
		chk(rises - r0, 2);
		boot(POL_EN_SC_DECL, 8'h03, 8'h03, 8'h00, 8'h00);
		ins <= 8'h01;
		idle(20);
		expect_mode(POL_EN_SC_DECL, 1'b1, BLINKS_TWO);
		apb(1'b0, OFS_DIAG, 32'h0);
		chk(s[DIAG_ABSENT_LSB +: 8], 8'h02);
		chk(input_hold, 8'hfe);
		cmd(CMD_ORIGIN);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(s[ST_WAITDL_BIT], 1'b1);
		chk(run_mode, 1'b0);
		ins <= 8'h03;
		idle(30);
		chk(run_mode, 1'b0);
		cmd(CMD_WARM);
		chk(run_mode, 1'b0);
		cmd(CMD_DOWNLOAD);
		expect_mode(POL_EN_SC_DECL, 1'b1, BLINKS_NONE);
		end_sim();
	end
endmodule // tb_hsbs_supervisor
